/* File: hrrp_asserts.sv */
`timescale 1ns/1ps
module hrrp_chk (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // Request handshakes.
    input wire logic IN_VALID,
    input wire logic IN_READY,
    input wire logic SETUP_VALID,
    input wire logic SETUP_READY,
    input wire logic SETUP_STALL,
    // Endpoint stream.
    input wire logic EP_VALID,
    input wire logic EP_READY,
    input wire logic EP_LAST,
    input wire logic [1:0] EP_NUM,
    input wire logic [7:0] EP_DATA
);
    logic first_r;
    logic [3:0] cnt_r;
    logic take_r;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_take;
        EP_VALID && EP_READY;
    endsequence
    sequence s_stall;
        EP_VALID && !EP_READY;
    endsequence
    // Tracks the position of the byte inside the current report.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            first_r <= 1'h1;
            cnt_r <= 4'h0;
        end else if (EP_VALID && EP_READY) begin
            first_r <= EP_LAST;
            cnt_r <= EP_LAST ? 4'h0 : cnt_r + 4'h1;
        end
    end
    always_ff @(posedge CLK) begin
        take_r <= RST_B && SETUP_VALID && SETUP_READY;
    end
    a_ep_hold: assert property (s_stall |=> EP_VALID && $stable({EP_NUM, EP_DATA, EP_LAST}))
        else $error("endpoint byte changed while stalled");
    a_param_id: assert property (EP_VALID && first_r && EP_NUM == 2'h0 |-> EP_DATA == 8'h04)
        else $error("parameter report does not start with its ID");
    a_aux_id: assert property (EP_VALID && first_r && EP_NUM == 2'h2 |-> EP_DATA inside {8'h01, 8'h02, 8'h03})
        else $error("auxiliary report does not start with an ID");
    a_param_len: assert property (s_take ##0 EP_LAST && EP_NUM == 2'h0 |-> cnt_r == 4'h7)
        else $error("parameter report length is not eight");
    a_aux_len: assert property (EP_VALID && EP_NUM == 2'h2 |-> cnt_r <= 4'h8)
        else $error("auxiliary report too long");
    a_ep_legal: assert property (EP_VALID |-> EP_NUM != 2'h3)
        else $error("endpoint number out of range");
    a_stall_once: assert property (SETUP_STALL |=> !SETUP_STALL)
        else $error("stall held longer than one cycle");
    a_stall_cause: assert property (SETUP_STALL |-> take_r)
        else $error("stall without a taken request");
    a_in_busy: assert property (IN_VALID && IN_READY |=> !IN_READY)
        else $error("report accepted while sending");
endmodule : hrrp_chk
bind hrrp_top hrrp_chk hrrp_chk_i (.CLK(CLK), .RST_B(RST_B), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .SETUP_VALID(SETUP_VALID), .SETUP_READY(SETUP_READY),
    .SETUP_STALL(SETUP_STALL), .EP_VALID(EP_VALID), .EP_READY(EP_READY), .EP_LAST(EP_LAST),
    .EP_NUM(EP_NUM), .EP_DATA(EP_DATA));

/* File: hrrp_buf.sv */
`timescale 1ns/1ps
module hrrp_buf #(
    parameter int W = 11,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_r [0:DEPTH-1];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : hrrp_buf

/* File: hrrp_defs.svh */
`ifndef HRRP_DEFS_SVH
`define HRRP_DEFS_SVH

`define HRRP_EP_CTRL 2'h0
`define HRRP_EP_KEYS 2'h1
`define HRRP_EP_AUX 2'h2

`define HRRP_ID_MOUSE 8'h01
`define HRRP_ID_MEDIA 8'h02
`define HRRP_ID_POWER 8'h03
`define HRRP_ID_PARAM 8'h04
`define HRRP_PARAM_LEN 4'h8

`define HRRP_USAGE_PAGE 16'hFF01
`define HRRP_USAGE_KBD 8'h01
`define HRRP_USAGE_MOUSE 8'h02
`define HRRP_USAGE_BATT 8'h20
`define HRRP_USAGE_XFER 8'h24

`define HRRP_RT_SET 8'h21
`define HRRP_RQ_SET 8'h09
`define HRRP_RT_GET 8'hA1
`define HRRP_RQ_GET 8'h01
`define HRRP_WVAL_PARAM 16'h0304
`define HRRP_IDX_KBD 16'h0000
`define HRRP_IDX_MOUSE 16'h0001

`define HRRP_BATT_MAX 8'h0A
`define HRRP_CHAN_MAX 8'h4D
`define HRRP_PN_MAX 8'h30
`define HRRP_CNT_MAX 16'hFFFF

`define HRRP_RST_BATT 8'h00
`define HRRP_RST_CHAN 8'h00
`define HRRP_RST_PN 8'h00
`define HRRP_RST_CNT 16'h0000
`define HRRP_RST_CTRL 32'h0000_0001

`define HRRP_OFS_CTRL 12'h000
`define HRRP_OFS_STAT 12'h004
`define HRRP_OFS_KPAR 12'h008
`define HRRP_OFS_MPAR 12'h00C
`define HRRP_OFS_KCNT 12'h010
`define HRRP_OFS_MCNT 12'h014
`define HRRP_CTRL_EN_BIT 0

`endif

/* File: hrrp_host.sv */
`timescale 1ns/1ps
module hrrp_host (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Endpoint stream from the bridge.
    input wire logic ep_valid,
    input wire logic [1:0] ep_num,
    input wire logic [7:0] ep_data,
    input wire logic ep_last,
    output logic ep_ready,
    // Pacing.
    input wire logic slow
);
    logic [10:0] q[$];
    // Each accepted byte is logged with its endpoint and end mark.
    always @(posedge clk) begin
        if (!rst_b) begin
            ep_ready <= 1'h0;
        end else begin
            if (ep_valid && ep_ready) begin
                q.push_back({ep_last, ep_num, ep_data});
            end
            ep_ready <= slow ? ($urandom_range(0, 3) == 0) : 1'h1;
        end
    end
endmodule : hrrp_host

/* File: hrrp_pkg.sv */
package hrrp_pkg;
    typedef enum logic [1:0] {
        HRRP_KIND_KEYS = 2'b00,
        HRRP_KIND_MOUSE = 2'b01,
        HRRP_KIND_MEDIA = 2'b10,
        HRRP_KIND_POWER = 2'b11
    } hrrp_kind_t;

    typedef enum logic [1:0] {
        HRRP_ST_IDLE = 2'b00,
        HRRP_ST_SEND = 2'b01
    } hrrp_state_t;
endpackage : hrrp_pkg

/* File: hrrp_top.sv */
`timescale 1ns/1ps
`include "hrrp_defs.svh"
module hrrp_top (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_B,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Radio packet events.
    input wire logic RADIO_PKT_VALID,
    input wire logic RADIO_DEV,
    input wire logic RADIO_ERR,
    input wire logic [7:0] RADIO_CHAN,
    input wire logic [7:0] RADIO_PN,
    input wire logic RADIO_BATT_VALID,
    input wire logic [7:0] RADIO_BATT,
    // Input reports from the radio side.
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire hrrp_pkg::hrrp_kind_t IN_KIND,
    input wire logic [3:0] IN_LEN,
    input wire logic [63:0] IN_DATA,
    // Control endpoint setup requests.
    input wire logic SETUP_VALID,
    output logic SETUP_READY,
    input wire logic [7:0] SETUP_TYPE,
    input wire logic [7:0] SETUP_REQ,
    input wire logic [15:0] SETUP_VALUE,
    input wire logic [15:0] SETUP_INDEX,
    output logic SETUP_STALL,
    // Endpoint byte stream toward the USB engine.
    output logic EP_VALID,
    input wire logic EP_READY,
    output logic [1:0] EP_NUM,
    output logic [7:0] EP_DATA,
    output logic EP_LAST
);
    import hrrp_pkg::*;

    hrrp_state_t state_r;
    logic [7:0] frm_r [0:8];
    logic [3:0] len_r;
    logic [3:0] pos_r;
    logic [1:0] ep_r;
    logic [31:0] ctrl_r;
    logic [31:0] prdata_r;
    logic [7:0] batt_r [0:1];
    logic [7:0] chan_r [0:1];
    logic [7:0] pn_r [0:1];
    logic [15:0] corr_r [0:1];
    logic [15:0] xfer_r [0:1];
    logic pend_r;
    logic pend_get_r;
    logic pend_dev_r;
    logic stall_r;
    logic buf_in_ready;
    logic buf_push;
    logic start_ctrl;
    logic start_data;
    logic setup_take;
    logic setup_match;
    logic setup_is_set;
    logic setup_is_get;
    logic route_en;
    logic [10:0] buf_in;
    logic [10:0] buf_out;
    logic [3:0] in_len_clip;

    assign route_en = ctrl_r[`HRRP_CTRL_EN_BIT];

    // Payloads longer than the eight-byte frame are cut to eight bytes.
    assign in_len_clip = (IN_LEN > 4'h8) ? 4'h8 : IN_LEN;

    // Setup decode: type, code, value and a known device index must all match.
    assign setup_is_set = (SETUP_TYPE == `HRRP_RT_SET) && (SETUP_REQ == `HRRP_RQ_SET);
    assign setup_is_get = (SETUP_TYPE == `HRRP_RT_GET) && (SETUP_REQ == `HRRP_RQ_GET);
    assign setup_match = (setup_is_set || setup_is_get) && (SETUP_VALUE == `HRRP_WVAL_PARAM) &&
        ((SETUP_INDEX == `HRRP_IDX_KBD) || (SETUP_INDEX == `HRRP_IDX_MOUSE));
    assign SETUP_READY = !pend_r;
    assign setup_take = SETUP_VALID && !pend_r;

    // A pending control answer has priority over data reports.
    assign start_ctrl = (state_r == HRRP_ST_IDLE) && pend_r;
    assign start_data = (state_r == HRRP_ST_IDLE) && !pend_r && IN_VALID && route_en;
    assign IN_READY = start_data;

    assign buf_push = (state_r == HRRP_ST_SEND);
    assign buf_in = {ep_r, (pos_r == len_r - 4'h1), frm_r[pos_r]};

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pend_r <= 1'b0;
            pend_get_r <= 1'b0;
            pend_dev_r <= 1'b0;
        end else if (setup_take && setup_match) begin
            pend_r <= 1'b1;
            pend_get_r <= setup_is_get;
            pend_dev_r <= (SETUP_INDEX == `HRRP_IDX_MOUSE);
        end else if (start_ctrl) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            stall_r <= 1'b0;
        end else begin
            stall_r <= setup_take && !setup_match;
        end
    end
    assign SETUP_STALL = stall_r;

    // SEND walks the frame one byte per accepted push; the buffer absorbs host stalls.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_r <= HRRP_ST_IDLE;
            pos_r <= 4'h0;
        end else begin
            unique case (state_r)
                HRRP_ST_IDLE: begin
                    pos_r <= 4'h0;
                    if (start_ctrl || start_data) begin
                        state_r <= HRRP_ST_SEND;
                    end
                end
                HRRP_ST_SEND: begin
                    if (buf_in_ready) begin
                        if (pos_r == len_r - 4'h1) begin
                            state_r <= HRRP_ST_IDLE;
                        end
                        pos_r <= pos_r + 4'h1;
                    end
                end
                default: begin
                    state_r <= HRRP_ST_IDLE;
                end
            endcase
        end
    end

    // Frame assembly: endpoint 2 frames carry the report ID in byte 0.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            len_r <= 4'h1;
            ep_r <= `HRRP_EP_CTRL;
            for (int i = 0; i < 9; i++) begin
                frm_r[i] <= 8'h00;
            end
        end else if (start_ctrl) begin
            ep_r <= `HRRP_EP_CTRL;
            len_r <= `HRRP_PARAM_LEN;
            frm_r[0] <= `HRRP_ID_PARAM;
            frm_r[1] <= batt_r[pend_dev_r];
            frm_r[2] <= chan_r[pend_dev_r];
            frm_r[3] <= pn_r[pend_dev_r];
            frm_r[4] <= corr_r[pend_dev_r][7:0];
            frm_r[5] <= corr_r[pend_dev_r][15:8];
            frm_r[6] <= xfer_r[pend_dev_r][7:0];
            frm_r[7] <= xfer_r[pend_dev_r][15:8];
            frm_r[8] <= 8'h00;
        end else if (start_data) begin
            if (IN_KIND == HRRP_KIND_KEYS) begin
                ep_r <= `HRRP_EP_KEYS;
                len_r <= (IN_LEN == 4'h0) ? 4'h1 : in_len_clip;
                for (int i = 0; i < 8; i++) begin
                    frm_r[i] <= IN_DATA[8*i +: 8];
                end
                frm_r[8] <= 8'h00;
            end else begin
                ep_r <= `HRRP_EP_AUX;
                len_r <= in_len_clip + 4'h1;
                unique case (IN_KIND)
                    HRRP_KIND_MOUSE: frm_r[0] <= `HRRP_ID_MOUSE;
                    HRRP_KIND_MEDIA: frm_r[0] <= `HRRP_ID_MEDIA;
                    HRRP_KIND_POWER: frm_r[0] <= `HRRP_ID_POWER;
                    default: frm_r[0] <= `HRRP_ID_MOUSE;
                endcase
                for (int i = 0; i < 8; i++) begin
                    frm_r[i+1] <= IN_DATA[8*i +: 8];
                end
            end
        end
    end

    // Per-device radio parameters.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int d = 0; d < 2; d++) begin
                batt_r[d] <= `HRRP_RST_BATT;
                chan_r[d] <= `HRRP_RST_CHAN;
                pn_r[d] <= `HRRP_RST_PN;
            end
        end else begin
            if (RADIO_PKT_VALID) begin
                chan_r[RADIO_DEV] <= (RADIO_CHAN > `HRRP_CHAN_MAX) ? `HRRP_CHAN_MAX : RADIO_CHAN;
                pn_r[RADIO_DEV] <= (RADIO_PN > `HRRP_PN_MAX) ? `HRRP_PN_MAX : RADIO_PN;
            end
            if (RADIO_BATT_VALID) begin
                batt_r[RADIO_DEV] <= (RADIO_BATT > `HRRP_BATT_MAX) ? `HRRP_BATT_MAX : RADIO_BATT;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int d = 0; d < 2; d++) begin
                corr_r[d] <= `HRRP_RST_CNT;
            end
        end else if (RADIO_PKT_VALID && RADIO_ERR && corr_r[RADIO_DEV] != `HRRP_CNT_MAX) begin
            corr_r[RADIO_DEV] <= corr_r[RADIO_DEV] + 16'h0001;
        end
    end

    // The count is cleared when a GET answer is latched; a packet in that cycle still counts.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int d = 0; d < 2; d++) begin
                xfer_r[d] <= `HRRP_RST_CNT;
            end
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (RADIO_PKT_VALID && !RADIO_ERR && RADIO_DEV == d[0]) begin
                    if (start_ctrl && pend_get_r && pend_dev_r == d[0]) begin
                        xfer_r[d] <= 16'h0001;
                    end else if (xfer_r[d] != `HRRP_CNT_MAX) begin
                        xfer_r[d] <= xfer_r[d] + 16'h0001;
                    end
                end else if (start_ctrl && pend_get_r && pend_dev_r == d[0]) begin
                    xfer_r[d] <= `HRRP_RST_CNT;
                end
            end
        end
    end

    // Each buffer word carries endpoint, end mark and byte together.
    hrrp_buf #(
        .W(11),
        .DEPTH(2)
    ) u_buf (
        .clk(CLK),
        .rst_b(RST_B),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(EP_VALID),
        .out_ready(EP_READY),
        .out_data(buf_out)
    );
    assign EP_NUM = buf_out[10:9];
    assign EP_LAST = buf_out[8];
    assign EP_DATA = buf_out[7:0];

    // APB slave: read data is latched in the setup cycle, so no wait states.
    assign PREADY = 1'b1;
    assign PRDATA = prdata_r;

    always_comb begin
        PSLVERR = 1'b0;
        if (PSEL && PENABLE) begin
            unique case (PADDR)
                `HRRP_OFS_CTRL, `HRRP_OFS_STAT, `HRRP_OFS_KPAR,
                `HRRP_OFS_MPAR, `HRRP_OFS_KCNT, `HRRP_OFS_MCNT: PSLVERR = 1'b0;
                default: PSLVERR = 1'b1;
            endcase
        end
    end

    // Only CTRL is writable; writes to any other offset are ignored.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ctrl_r <= `HRRP_RST_CTRL;
        end else if (PSEL && PENABLE && PWRITE && PADDR == `HRRP_OFS_CTRL) begin
            ctrl_r <= {31'h0000_0000, PWDATA[`HRRP_CTRL_EN_BIT]};
        end
    end

    // Read data captured in the setup phase stands through the access phase.
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            prdata_r <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            unique case (PADDR)
                `HRRP_OFS_CTRL: prdata_r <= ctrl_r;
                `HRRP_OFS_STAT: prdata_r <= {28'h000_0000, EP_VALID, pend_r,
                    (state_r == HRRP_ST_SEND), route_en};
                `HRRP_OFS_KPAR: prdata_r <= {8'h00, pn_r[0], chan_r[0], batt_r[0]};
                `HRRP_OFS_MPAR: prdata_r <= {8'h00, pn_r[1], chan_r[1], batt_r[1]};
                `HRRP_OFS_KCNT: prdata_r <= {xfer_r[0], corr_r[0]};
                `HRRP_OFS_MCNT: prdata_r <= {xfer_r[1], corr_r[1]};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end
endmodule : hrrp_top

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import hrrp_pkg::*;
    logic CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic PREADY, PSLVERR, IN_READY, SETUP_READY, SETUP_STALL, EP_VALID, EP_READY, EP_LAST;
    logic RADIO_PKT_VALID = 0, RADIO_DEV = 0, RADIO_ERR = 0, RADIO_BATT_VALID = 0;
    logic [7:0] RADIO_CHAN = 0, RADIO_PN = 0, RADIO_BATT = 0, EP_DATA;
    logic IN_VALID = 0, SETUP_VALID = 0;
    hrrp_kind_t IN_KIND = HRRP_KIND_KEYS;
    logic [3:0] IN_LEN = 0;
    logic [63:0] IN_DATA = 0;
    logic [7:0] SETUP_TYPE = 0, SETUP_REQ = 0;
    logic [15:0] SETUP_VALUE = 0, SETUP_INDEX = 0;
    logic [1:0] EP_NUM;
    logic [7:0] bt[2] = '{8'h00, 8'h00}, ch[2] = '{8'h00, 8'h00}, pn[2] = '{8'h00, 8'h00};
    logic [15:0] corr[2] = '{16'h0000, 16'h0000}, xf[2] = '{16'h0000, 16'h0000};
    int n_fail = 0, n_compared = 0, cyc = 0;
    hrrp_top hrrp_top_i (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RADIO_PKT_VALID(RADIO_PKT_VALID), .RADIO_DEV(RADIO_DEV),
        .RADIO_ERR(RADIO_ERR), .RADIO_CHAN(RADIO_CHAN), .RADIO_PN(RADIO_PN),
        .RADIO_BATT_VALID(RADIO_BATT_VALID), .RADIO_BATT(RADIO_BATT), .IN_VALID(IN_VALID),
        .IN_READY(IN_READY), .IN_KIND(IN_KIND), .IN_LEN(IN_LEN), .IN_DATA(IN_DATA),
        .SETUP_VALID(SETUP_VALID), .SETUP_READY(SETUP_READY), .SETUP_TYPE(SETUP_TYPE),
        .SETUP_REQ(SETUP_REQ), .SETUP_VALUE(SETUP_VALUE), .SETUP_INDEX(SETUP_INDEX),
        .SETUP_STALL(SETUP_STALL), .EP_VALID(EP_VALID), .EP_READY(EP_READY),
        .EP_NUM(EP_NUM), .EP_DATA(EP_DATA), .EP_LAST(EP_LAST));
    hrrp_host hrrp_host_i (.clk(CLK), .rst_b(RST_B), .ep_valid(EP_VALID), .ep_num(EP_NUM),
        .ep_data(EP_DATA), .ep_last(EP_LAST), .ep_ready(EP_READY), .slow(slow));
    initial begin
        forever #20 CLK = ~CLK;
    end
    task stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        n_compared++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    function automatic logic [7:0] lim(input logic [7:0] v, input logic [7:0] m);
        return (v > m) ? m : v;
    endfunction : lim
    function automatic logic [7:0] exp_id(input hrrp_kind_t kd);
        return (kd == HRRP_KIND_MOUSE) ? 8'h01 : (kd == HRRP_KIND_MEDIA) ? 8'h02 : 8'h03;
    endfunction : exp_id
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge CLK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        do @(posedge CLK); while (PREADY !== 1'h1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask : apb
    task wait_q(input int n);
        for (int t = 0; t < 400 && hrrp_host_i.q.size() < n; t++) @(posedge CLK);
    endtask : wait_q
    task pop(input logic [1:0] ep, input logic [7:0] x, input logic l);
        logic [10:0] v;
        v = hrrp_host_i.q.size() ? hrrp_host_i.q.pop_front() : 11'h7FF;
        chk("ep_num", ep, v[9:8]);
        chk("ep_data", x, v[7:0]);
        chk("ep_last", l, v[10]);
    endtask : pop
    task send(input hrrp_kind_t kd, input logic [3:0] n);
        logic [63:0] d;
        logic b;
        d = {$urandom, $urandom};
        b = kd != HRRP_KIND_KEYS;
        @(posedge CLK);
        IN_VALID <= 1;
        IN_KIND <= kd;
        IN_LEN <= n;
        IN_DATA <= d;
        do @(posedge CLK); while (IN_READY !== 1'h1);
        IN_VALID <= 0;
        wait_q(n + b);
        if (b) pop(2'h2, exp_id(kd), 1'h0);
        for (int i = 0; i < n; i++) pop(b ? 2'h2 : 2'h1, d[8*i+:8], i == n - 1);
    endtask : send
    task radio(input logic d, input logic er, input int n);
        logic [7:0] c;
        logic [7:0] p;
        repeat (n) begin
            @(posedge CLK);
            c = 8'($urandom_range(0, 100));
            p = 8'($urandom_range(0, 64));
            ch[d] = lim(c, 8'h4D);
            pn[d] = lim(p, 8'h30);
            RADIO_PKT_VALID <= 1;
            RADIO_DEV <= d;
            RADIO_ERR <= er;
            RADIO_CHAN <= c;
            RADIO_PN <= p;
            if (er) corr[d]++;
            else xf[d]++;
        end
        @(posedge CLK);
        RADIO_PKT_VALID <= 0;
    endtask : radio
    task bat(input logic d, input logic [7:0] v);
        @(posedge CLK);
        RADIO_BATT_VALID <= 1;
        RADIO_DEV <= d;
        RADIO_BATT <= v;
        bt[d] = lim(v, 8'h0A);
        @(posedge CLK);
        RADIO_BATT_VALID <= 0;
    endtask : bat
    task setup(input logic [7:0] ty, input logic [7:0] rq, input logic [15:0] ix);
        @(posedge CLK);
        SETUP_VALID <= 1;
        SETUP_TYPE <= ty;
        SETUP_REQ <= rq;
        SETUP_VALUE <= 16'h0304;
        SETUP_INDEX <= ix;
        do @(posedge CLK); while (SETUP_READY !== 1'h1);
        SETUP_VALID <= 0;
    endtask : setup
    task param(input logic d);
        wait_q(8);
        pop(2'h0, 8'h04, 1'h0);
        pop(2'h0, bt[d], 1'h0);
        pop(2'h0, ch[d], 1'h0);
        pop(2'h0, pn[d], 1'h0);
        pop(2'h0, corr[d][7:0], 1'h0);
        pop(2'h0, corr[d][15:8], 1'h0);
        pop(2'h0, xf[d][7:0], 1'h0);
        pop(2'h0, xf[d][15:8], 1'h1);
    endtask : param
    initial begin
        logic [31:0] r;
        logic e;
        void'($urandom(21787));
        repeat (8) @(posedge CLK);
        RST_B <= 1;
        apb(0, 12'h000, 0, r, e);
        chk("ctrl", 16'h0001, r[15:0]);
        apb(0, 12'h018, 0, r, e);
        chk("pslverr", 16'h0001, {15'h0000, e});
        chk("prdata", 16'h0000, r[15:0]);
        apb(1, 12'h000, 32'h0000_0000, r, e);
        apb(0, 12'h000, 0, r, e);
        chk("ctrl", 16'h0000, r[15:0]);
        IN_VALID <= 1;
        repeat (4) begin
            @(posedge CLK);
            chk("in_ready", 16'h0000, {15'h0000, IN_READY});
        end
        IN_VALID <= 0;
        apb(1, 12'h000, 32'h0000_0001, r, e);
        for (int k = 0; k < 12; k++) begin
            slow <= k[2];
            send(hrrp_kind_t'(k[1:0]), k < 4 ? 4'h8 : 4'($urandom_range(1, 8)));
        end
        for (int d = 0; d < 2; d++) begin
            slow <= d[0];
            setup(8'hA1, 8'h01, 16'(d));
            param(d);
            bat(d, 8'($urandom_range(0, 10)));
            radio(d, 0, $urandom_range(200, 300));
            radio(d, 1, $urandom_range(1, 5));
            setup(8'h21, 8'h09, 16'(d));
            param(d);
            bat(d, 8'hFF);
            setup(8'hA1, 8'h01, 16'(d));
            param(d);
            xf[d] = 0;
            setup(8'hA1, 8'h01, 16'(d));
            param(d);
        end
        apb(0, 12'h008, 0, r, e);
        chk("kpar", {ch[0], bt[0]}, r[15:0]);
        chk("kpar_pn", {8'h00, pn[0]}, r[31:16]);
        apb(0, 12'h010, 0, r, e);
        chk("kcnt_corr", corr[0], r[15:0]);
        chk("kcnt_xfer", xf[0], r[31:16]);
        setup(8'hA1, 8'h01, 16'h0002);
        @(posedge CLK);
        chk("setup_stall", 16'h0001, {15'h0000, SETUP_STALL});
        setup(8'hA1, 8'h09, 16'h0000);
        @(posedge CLK);
        chk("setup_stall", 16'h0001, {15'h0000, SETUP_STALL});
        repeat (20) @(posedge CLK);
        chk("ep_queue", 16'h0000, 16'(hrrp_host_i.q.size()));
        stop_test();
    end
endmodule : tb
